// [rtl/fmts_pkg.sv]
package fmts_pkg;

	// ---------------------------------------------------------------
	// fault indices, ordered from highest priority downward
	// ---------------------------------------------------------------
	localparam int NF     = 15;
	localparam int F_MEM  = 0;
	localparam int F_DSS  = 1;
	localparam int F_GDS  = 2;
	localparam int F_GSS  = 3;
	localparam int F_URX  = 4;
	localparam int F_SOC  = 5;
	localparam int F_HT   = 6;
	localparam int F_DTT  = 7;
	localparam int F_CIH  = 8;
	localparam int F_IHV  = 9;
	localparam int F_ILV  = 10;
	localparam int F_OLV  = 11;
	localparam int F_STO  = 12;
	localparam int F_CLT  = 13;
	localparam int F_SAT  = 14;

	// ---------------------------------------------------------------
	// register map (byte addresses) and fields
	// ---------------------------------------------------------------
	localparam logic [7:0] A_TURNOFF = 8'h00;
	localparam logic [7:0] A_ENABLE  = 8'h04;
	localparam logic [7:0] A_MASK    = 8'h08;
	localparam logic [7:0] A_STATUS  = 8'h0C;
	localparam logic [7:0] A_CMD     = 8'h10;
	localparam logic [7:0] A_STATE   = 8'h14;
	localparam logic [7:0] A_OUTCFG  = 8'h18;
	localparam int B_FASTSEL = 0;
	localparam int B_SLOWLO  = 1;
	localparam int B_TMRLO   = 4;
	localparam int TMR_W     = 8;
	localparam int B_CLEAR   = 0;
	localparam int B_RESTART = 1;
	localparam int B_POL     = 0;
	localparam int B_AL_G0   = 1;
	localparam int B_AL_G3   = 2;
	localparam int B_SRC_F   = 3;
	localparam int B_SRC_W   = 4;
	localparam logic [11:0] RST_TURNOFF = 12'h000;
	localparam logic [NF-1:0] RST_ENABLE = 15'h7FFF;
	localparam logic [NF-1:0] RST_MASK   = 15'h0000;
	localparam logic [4:0]  RST_OUTCFG  = 5'h08;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam longint CLK_HZ       = 40_000_000;
	localparam longint RESTART_S    = 10;
	localparam longint RESTART_CYC  = RESTART_S * CLK_HZ;
	localparam longint FLTMIN_US    = 1000;
	localparam longint FLTMIN_CYC   = (FLTMIN_US * CLK_HZ + 999_999) / 1_000_000;

	// controller operating state as reported by the main sequencer
	typedef enum logic [3:0] {
		OP_POR = 4'h0, OP_RDCFG = 4'h1, OP_CHK = 4'h2, OP_STBY = 4'h3,
		OP_INIT = 4'h4, OP_ON = 4'h5, OP_IREG = 4'h6, OP_FAULT = 4'h7,
		OP_WAIT = 4'h8, OP_LATCH = 4'h9
	} fmts_op_t;

	typedef enum logic [4:0] {
		G_IDLE = 5'b00001, G_SINK = 5'b00010, G_RES = 5'b00100,
		G_SLOW = 5'b01000, G_OFF = 5'b10000
	} fmts_gate_t;

	typedef struct packed {
		logic       strong_sink;
		logic       res_discharge;
		logic       slow_sink;
		logic [1:0] slow_level;
	} fmts_drive_t;

endpackage : fmts_pkg

// [rtl/fmts_fault_mgr.sv]
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps

// Contract
// - first step is 1.5A sink or resistor; sink runs to fully off, no step two
// - resistor step discharges for fast_stage_timer, started at turn-off
// - timer expiry switches to slow_pulldown_level until switch is off
// - zero timer with select one gives slow pull-down only
// - restart turns off, waits ten seconds, then returns to standby
// - slow pull-down level picks 250uA, 500uA, 750uA or 1.25mA
// - each fault has its own sticky readable flag
// - fault alert pin shows OR of unmasked flags, polarity programmable
// - indicator_pin driven low while any unmasked flag is set
// - bus alert active low, faults/warnings/both, on general output 0 or 3
// - mask selects which faults reach the pins
// - any fault drops supply_ok_output
// - disabled faults are neither detected nor reported
// - flags and pins hold until clear command, enable toggle or power cycle
// - fault alert stays asserted at least the minimum hold time
// - clears and enable toggles ignored during fault processing
// - strictly higher priority fault preempts and the held one resumes; the code preempts only while no fault is already held
// - priority order memory, switch shorts, severe overcurrent ... overcurrent
// - each fault is detected only in its listed operating states
// - retry_exhausted raised only in fault state on retry expiry
module fmts_fault_mgr
	import fmts_pkg::*;
#(
	parameter longint RESTART_CYCLES = fmts_pkg::RESTART_CYC,
	parameter longint FLTMIN_CYCLES  = fmts_pkg::FLTMIN_CYC
)(
	// clock and reset
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	// ahb-lite slave
	input  wire logic                  hsel,
	input  wire logic [7:0]            haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic                  hready,
	input  wire logic [31:0]           hwdata,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	// analog and sequencer side
	input  wire logic [NF-1:0]         fault_cond,
	input  wire logic                  warn_in,
	input  fmts_pkg::fmts_op_t         op_state,
	input  wire logic                  fet_off,
	input  wire logic                  service_done,
	input  wire logic                  en_pin,
	input  wire logic                  pg_cond,
	output fmts_pkg::fmts_drive_t      gate_drive,
	output logic                       ten_second_wait_state,
	output logic                       standby_request,
	output logic                       supply_ok_output,
	output logic                       fault_processing,
	// open-drain pins, enable low drives the pin low
	output logic                       general_output_0_out,
	output logic                       general_output_0_oe_n,
	output logic                       indicator_pin_out,
	output logic                       indicator_pin_oe_n,
	output logic                       general_output_3_out,
	output logic                       general_output_3_oe_n
);
	import fmts_pkg::*;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [3:0] prio_group(input logic [3:0] idx);
		unique case (idx)
			4'h0: prio_group = 4'h1;
			4'h1, 4'h2, 4'h3, 4'h4: prio_group = 4'h2;
			4'h5: prio_group = 4'h3;
			4'h6, 4'h7: prio_group = 4'h4;
			4'h8: prio_group = 4'h5;
			4'h9: prio_group = 4'h6;
			4'hA: prio_group = 4'h7;
			4'hB: prio_group = 4'h8;
			4'hC: prio_group = 4'h9;
			default: prio_group = 4'hA;
		endcase
	endfunction : prio_group

	function automatic logic [NF-1:0] allowed(input fmts_op_t s);
		logic [NF-1:0] a;
		a = '0;
		a[F_MEM] = (s == OP_RDCFG) || (s == OP_STBY);
		a[F_DSS] = (s == OP_CHK) || (s == OP_STBY) || (s == OP_FAULT);
		a[F_GDS] = a[F_DSS];
		a[F_GSS] = (s == OP_INIT);
		a[F_URX] = (s == OP_FAULT);
		a[F_SOC] = (s == OP_INIT) || (s == OP_ON) || (s == OP_IREG);
		a[F_HT]  = a[F_SOC] || (s == OP_STBY) || (s == OP_FAULT);
		a[F_DTT] = a[F_HT];
		a[F_CIH] = a[F_HT];
		a[F_IHV] = a[F_HT];
		a[F_ILV] = a[F_HT];
		a[F_OLV] = (s == OP_ON) || (s == OP_IREG);
		a[F_STO] = (s == OP_INIT);
		a[F_CLT] = a[F_OLV];
		a[F_SAT] = a[F_OLV];
		allowed = a;
	endfunction : allowed

	function automatic logic [4:0] first_set(input logic [NF-1:0] v);
		first_set = 5'h1F;
		for (int i = NF - 1; i >= 0; i--)
			if (v[i])
				first_set = 5'(i);
	endfunction : first_set

	// ---------------------------------------------------------------
	// registers and bus
	// ---------------------------------------------------------------
	logic [11:0]     turnoff;
	logic [NF-1:0]   fault_enable;
	logic [NF-1:0]   fault_mask;
	logic [NF-1:0]   flags;
	logic [4:0]      outcfg;
	logic            dp_wr;
	logic [7:0]      dp_addr;
	logic            clr_req;
	logic            rst_cmd;
	logic            clr_ok;
	logic            en_q;
	logic            en_toggle;
	logic [NF-1:0]   det;
	fmts_gate_t      gseq;
	logic [TMR_W-1:0] tmr;
	logic [3:0]      active_idx;
	logic            active_v;
	logic [3:0]      held_idx;
	logic            held_v;
	logic [NF-1:0]   pending;
	logic [31:0]     wait_cnt;
	logic [31:0]     hold_cnt;
	logic            fault_act;
	logic            alert_act;
	logic [NF-1:0]   shown;
	logic            dp_addr_ok;

	// only word-aligned addresses reach the configuration registers; transfer size is not checked
	assign dp_addr_ok = (dp_addr[1:0] == 2'b00);
	wire addr_ph = hsel && htrans[1] && hready;
	wire wr_cmd  = dp_wr && (dp_addr == A_CMD);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_wr     <= 1'b0;
			dp_addr   <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			dp_wr   <= addr_ph && hwrite;
			dp_addr <= haddr;
			if (addr_ph && !hwrite)
			begin
				unique case (haddr)
					A_TURNOFF: hrdata <= {20'h00000, turnoff};
					A_ENABLE:  hrdata <= {17'h00000, fault_enable};
					A_MASK:    hrdata <= {17'h00000, fault_mask};
					A_STATUS:  hrdata <= {17'h00000, flags};
					A_STATE:   hrdata <= {16'h0000, active_v, active_idx, held_v,
						held_idx, 1'b0, gseq};
					A_OUTCFG:  hrdata <= {27'h0000000, outcfg};
					default:   hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// software-written configuration steers the sequencer and the pins
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			turnoff      <= RST_TURNOFF;
			fault_enable <= RST_ENABLE;
			fault_mask   <= RST_MASK;
			outcfg       <= RST_OUTCFG;
		end
		else if (dp_wr && dp_addr_ok)
		begin
			unique case (dp_addr)
				A_TURNOFF: turnoff      <= hwdata[11:0];
				A_ENABLE:  fault_enable <= hwdata[NF-1:0];
				A_MASK:    fault_mask   <= hwdata[NF-1:0];
				A_OUTCFG:  outcfg       <= hwdata[4:0];
				default:   ;
			endcase
		end
	end

	assign clr_req = wr_cmd && hwdata[B_CLEAR];
	assign rst_cmd = wr_cmd && hwdata[B_RESTART];

	// ---------------------------------------------------------------
	// detection and sticky flags
	// ---------------------------------------------------------------
	// detection gating
	assign det = fault_cond & fault_enable & allowed(op_state);

	// clears are ignored, not deferred, while processing is under way
	assign clr_ok    = !active_v && (op_state != OP_FAULT);
	assign en_toggle = en_q && !en_pin;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			en_q <= 1'b1;
		else
			en_q <= en_pin;
	end

	// sticky flags, a new event wins over a clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			flags <= '0;
		else if ((clr_req || en_toggle) && clr_ok)
			flags <= det;
		else
			flags <= flags | det;
	end

	// ---------------------------------------------------------------
	// priority servicing
	// ---------------------------------------------------------------
	wire [NF-1:0] arrivals = det & ~flags;
	wire [4:0]    arr_first = first_set(arrivals);
	wire [4:0]    pend_first = first_set(pending);

	// preemption by strictly higher group only
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			active_v   <= 1'b0;
			active_idx <= 4'h0;
			held_v     <= 1'b0;
			held_idx   <= 4'h0;
			pending    <= '0;
		end
		else if (!active_v || service_done)
		begin
			pending <= pending | arrivals;
			if (held_v)
			begin
				active_v   <= 1'b1;
				active_idx <= held_idx;
				held_v     <= 1'b0;
			end
			else if (!pend_first[4])
			begin
				active_v   <= 1'b1;
				active_idx <= pend_first[3:0];
				pending    <= (pending | arrivals) & ~(NF'(1) << pend_first[3:0]);
			end
			else
			begin
				active_v   <= !arr_first[4];
				active_idx <= arr_first[3:0];
				pending    <= arrivals & ~(NF'(1) << arr_first[3:0]);
			end
		end
		else if (!arr_first[4] && !held_v &&
			prio_group(arr_first[3:0]) < prio_group(active_idx))
		begin
			held_v     <= 1'b1;
			held_idx   <= active_idx;
			active_idx <= arr_first[3:0];
			pending    <= pending | (arrivals & ~(NF'(1) << arr_first[3:0]));
		end
		else
			pending <= pending | arrivals;
	end

	// ---------------------------------------------------------------
	// gate turn-off sequencer
	// ---------------------------------------------------------------
	wire fast_trig = arrivals[F_SOC] || arrivals[F_CIH];
	wire trig      = (|arrivals) || rst_cmd;
	wire sel_res   = turnoff[B_FASTSEL];
	wire [TMR_W-1:0] tmr_set = turnoff[B_TMRLO +: TMR_W];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			gseq <= G_IDLE;
			tmr  <= '0;
		end
		else
		begin
			unique case (gseq)
				G_IDLE, G_OFF:
				begin
					if (trig && fast_trig && !sel_res)
						gseq <= G_SINK;
					else if (trig && fast_trig && tmr_set != '0)
					begin
						gseq <= G_RES;
						tmr  <= tmr_set;
					end
					else if (trig)
						gseq <= G_SLOW;
					else if (gseq == G_OFF && !ten_second_wait_state &&
						op_state != OP_FAULT)
						gseq <= G_IDLE;
				end
				G_SINK:
					if (fet_off)
						gseq <= G_OFF;
				G_RES:
				begin
					tmr <= tmr - TMR_W'(1);
					if (tmr == TMR_W'(1))
						gseq <= G_SLOW;
				end
				G_SLOW:
					if (fet_off)
						gseq <= G_OFF;
			endcase
		end
	end

	// slow level carried to the analog sink
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			gate_drive <= '0;
		else
		begin
			gate_drive.strong_sink   <= (gseq == G_SINK);
			gate_drive.res_discharge <= (gseq == G_RES);
			gate_drive.slow_sink     <= (gseq == G_SLOW);
			gate_drive.slow_level    <= turnoff[B_SLOWLO +: 2];
		end
	end

	// ---------------------------------------------------------------
	// restart wait
	// ---------------------------------------------------------------
	// ten second wait then standby
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ten_second_wait_state <= 1'b0;
			wait_cnt              <= '0;
			standby_request       <= 1'b0;
		end
		else
		begin
			standby_request <= 1'b0;
			if (rst_cmd)
			begin
				ten_second_wait_state <= 1'b1;
				wait_cnt              <= 32'(RESTART_CYCLES - 1);
			end
			else if (ten_second_wait_state)
			begin
				wait_cnt <= wait_cnt - 32'h1;
				if (wait_cnt == 32'h0)
				begin
					ten_second_wait_state <= 1'b0;
					standby_request       <= 1'b1;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// indication pins
	// ---------------------------------------------------------------
	// mask on all three pins
	assign shown = flags & ~fault_mask;
	wire alert_next = (outcfg[B_SRC_F] && |shown) || (outcfg[B_SRC_W] && warn_in);

	// minimum assertion of the fault pin
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hold_cnt <= '0;
		else if (|(arrivals & ~fault_mask))
			hold_cnt <= 32'(FLTMIN_CYCLES);
		else if (hold_cnt != 32'h0)
			hold_cnt <= hold_cnt - 32'h1;
	end

	assign fault_act = (|shown) || (hold_cnt != 32'h0);
	assign alert_act = alert_next;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			general_output_0_out  <= 1'b0;
			general_output_0_oe_n <= 1'b1;
			indicator_pin_out     <= 1'b0;
			indicator_pin_oe_n    <= 1'b1;
			general_output_3_out  <= 1'b0;
			general_output_3_oe_n <= 1'b1;
			supply_ok_output      <= 1'b0;
			fault_processing      <= 1'b0;
		end
		else
		begin
			// bus alert is active low on its chosen output
			if (outcfg[B_AL_G0])
				general_output_0_oe_n <= !alert_act;
			else
				// polarity sets whether active drives low
				general_output_0_oe_n <= !(fault_act ^ outcfg[B_POL]);
			general_output_3_oe_n <= !(outcfg[B_AL_G3] && alert_act);
			// indicator low on any unmasked fault
			indicator_pin_oe_n    <= !(|shown);
			supply_ok_output      <= pg_cond && !(|flags) && !(|det);
			fault_processing      <= active_v;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_flag_sets: assert property (|det |=> ((flags & $past(det)) == $past(det)))
		else $error("detected fault not flagged");
	a_flag_sticky: assert property (!(clr_req && clr_ok) && !(en_toggle && clr_ok)
		|=> (($past(flags) & ~flags) == '0))
		else $error("flag dropped without clear");
	a_clr_ignored: assert property (clr_req && !clr_ok
		|=> ((flags & $past(flags)) == $past(flags)))
		else $error("clear acted during processing");
	a_en_gating: assert property (1'b1
		|=> ((flags & ~$past(flags) & ~$past(fault_enable)) == '0))
		else $error("disabled fault flagged");
	a_res_expiry: assert property (gseq == G_RES && tmr == TMR_W'(1)
		|=> gseq == G_SLOW ##1 gate_drive.slow_sink)
		else $error("resistor stage did not hand over");
	a_sink_holds: assert property (gseq == G_SINK && !fet_off
		|=> gseq == G_SINK ##1 !gate_drive.slow_sink)
		else $error("strong sink left early");
	a_pg_drop: assert property (|flags |=> !supply_ok_output)
		else $error("supply ok with fault set");
	a_ind_low: assert property (|shown |=> !indicator_pin_oe_n)
		else $error("indicator not driven");
	a_hold_min: assert property (hold_cnt > 32'h2 |=> fault_act [*2])
		else $error("fault pin released early");
	a_restart: assert property (rst_cmd |=> ten_second_wait_state && !standby_request)
		else $error("restart wait not entered");

	c_preempt: cover property (held_v && active_v);
	c_two_step: cover property (gseq == G_RES ##1 gseq == G_SLOW);
	c_restart: cover property (standby_request);

endmodule : fmts_fault_mgr

// [verif/fmts_host.sv]
`timescale 1ns/1ps

// ---------------------------------------------------------------
// host side of the register bus, one word per transfer
// ---------------------------------------------------------------
module fmts_host (
	// bus clock and answer
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	// master request
	output logic             hsel,
	output logic [7:0]       haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	// last read word; count steps once per read
	output logic [31:0]      rd_val,
	output int               rd_cnt
);
	initial
	begin
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		rd_val = 32'h0;
		rd_cnt = 0;
	end

	// no memory access
	// the host never reaches configuration memory, so a restart wait is safe
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		if (!w)
		begin
			rd_val <= hrdata;
			rd_cnt <= rd_cnt + 1;
		end
	endtask : xfer
endmodule : fmts_host

// [verif/fault_manager_turnoff_seq_bench.sv]
`timescale 1ns/1ps

module fault_manager_turnoff_seq_bench;
	import fmts_pkg::*;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	localparam int RC = 60;
	localparam int T = 12;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [NF-1:0] fault_cond = '0;
	fmts_op_t op_state = OP_STBY;
	logic fet_off = 1'b1;
	logic service_done = 1'b0;
	logic en_pin = 1'b1;
	logic warn_in = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, ten_second_wait_state, standby_request;
	logic supply_ok_output, fault_processing;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, m;
	logic [63:0] qv;
	fmts_drive_t gate_drive;
	logic go0_o, go0_n, ind_o, ind_n, go3_o, go3_n;
	logic [63:0] exp_q[$];
	int err_count = 0;
	int check_count = 0;
	int seed = 46;
	int n;

	fmts_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .rd_val(), .rd_cnt());

	fmts_fault_mgr #(.RESTART_CYCLES(RC), .FLTMIN_CYCLES(8)) dut (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.fault_cond(fault_cond), .warn_in(warn_in), .op_state(op_state),
		.fet_off(fet_off), .service_done(service_done), .en_pin(en_pin),
		.pg_cond(1'b1), .gate_drive(gate_drive),
		.ten_second_wait_state(ten_second_wait_state),
		.standby_request(standby_request), .supply_ok_output(supply_ok_output),
		.fault_processing(fault_processing), .general_output_0_out(go0_o),
		.general_output_0_oe_n(go0_n), .indicator_pin_out(ind_o),
		.indicator_pin_oe_n(ind_n), .general_output_3_out(go3_o),
		.general_output_3_oe_n(go3_n));

	initial
	begin
		forever #12.5 hclk = ~hclk;
	end

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk

	task test_done;
		if (err_count == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done

	task cyc(input int k);
		repeat (k) @(posedge hclk);
	endtask : cyc

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		host.xfer(1'b1, a, d);
	endtask : wr

	task rdm(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
		exp_q.push_back({mk, e});
		@(posedge hclk);
		host.xfer(1'b0, a, 32'h0);
	endtask : rdm

	task raise(input int i);
		@(posedge hclk);
		op_state <= OP_ON;
		fet_off <= 1'b0;
		fault_cond <= fault_cond | (NF'(1) << i);
	endtask : raise

	task fin(input logic cmd);
		@(posedge hclk);
		fault_cond <= '0;
		fet_off <= 1'b1;
		service_done <= 1'b1;
		@(posedge hclk);
		service_done <= 1'b0;
		op_state <= OP_STBY;
		cyc(2);
		if (cmd)
			wr(A_CMD, 32'h1);
		else
		begin
			en_pin <= 1'b0;
			cyc(2);
			en_pin <= 1'b1;
		end
		cyc(2);
	endtask : fin

	task cnt(input int len, output int k);
		k = 0;
		repeat (len)
		begin
			@(negedge hclk);
			if (gate_drive.res_discharge === 1'b1)
				k++;
		end
	endtask : cnt

	always @(host.rd_cnt)
	begin
		qv = exp_q.pop_front();
		chk(host.rd_val & qv[63:32], qv[31:0]);
	end

	initial
	begin
		#500000;
		err_count++;
		test_done;
	end

	// ---------------------------------------------------------------
	// sequence
	// ---------------------------------------------------------------
	initial
	begin
		cyc(2);
		hresetn <= 1'b1;
		rdm(A_ENABLE, RST_ENABLE, '1);
		rdm(A_MASK, 32'h0, '1);
		rdm(A_OUTCFG, RST_OUTCFG, '1);
		rdm(8'h3C, 32'h0, '1);
		m = $random(seed);
		wr(A_MASK, m);
		rdm(A_MASK, m & 32'h7FFF, '1);
		wr(A_MASK, 32'h0);
		@(posedge hclk);
		op_state <= OP_ON;
		cyc(4);
		@(negedge hclk);
		chk(supply_ok_output, 1);
		raise(F_SOC);
		cyc(10);
		@(negedge hclk);
		chk(gate_drive.strong_sink, 1);
		chk(gate_drive.slow_sink, 0);
		chk(ind_n, 0);
		chk(go0_n, 0);
		chk(supply_ok_output, 0);
		chk(fault_processing, 1);
		chk({go0_o, ind_o, go3_o}, 0);
		chk(hresp, 0);
		@(posedge hclk);
		op_state <= OP_FAULT;
		wr(A_CMD, 32'h1);
		rdm(A_STATUS, 32'h1 << F_SOC, '1);
		fin(1'b1);
		rdm(A_STATUS, 32'h0, '1);
		@(negedge hclk);
		chk(gate_drive, 0);
		chk(ind_n, 1);
		chk(fault_processing, 0);
		wr(A_TURNOFF, (T << 4) | (2 << 1) | 1);
		raise(F_CIH);
		cnt(T + 8, n);
		chk(n, T);
		chk(gate_drive.slow_sink, 1);
		chk(gate_drive.slow_level, 2);
		fin(1'b0);
		rdm(A_STATUS, 32'h0, '1);
		for (int l = 0; l < 4; l++)
		begin
			wr(A_TURNOFF, (l << 1) | 1);
			raise(F_CIH);
			cnt(6, n);
			chk(n, 0);
			chk(gate_drive.slow_sink, 1);
			chk(gate_drive.slow_level, l);
			fin(1'b1);
		end
		wr(A_ENABLE, 32'h7FFF & ~(32'h1 << F_IHV));
		raise(F_IHV);
		cyc(4);
		rdm(A_STATUS, 32'h0, '1);
		@(negedge hclk);
		chk(ind_n, 1);
		fin(1'b1);
		wr(A_ENABLE, 32'h7FFF);
		@(posedge hclk);
		fault_cond <= NF'(1) << F_OLV;
		cyc(4);
		rdm(A_STATUS, 32'h0, '1);
		raise(F_OLV);
		cyc(3);
		rdm(A_STATUS, 32'h1 << F_OLV, '1);
		fin(1'b1);
		wr(A_OUTCFG, 32'h0D);
		@(posedge hclk);
		@(negedge hclk);
		chk(go0_n, 0);
		chk(go3_n, 1);
		raise(F_ILV);
		cyc(4);
		@(negedge hclk);
		chk(go0_n, 1);
		chk(go3_n, 0);
		fin(1'b1);
		wr(A_MASK, 32'h1 << F_ILV);
		raise(F_ILV);
		cyc(4);
		rdm(A_STATUS, 32'h1 << F_ILV, '1);
		@(negedge hclk);
		chk(ind_n, 1);
		chk(go3_n, 1);
		chk(go0_n, 0);
		fin(1'b1);
		wr(A_MASK, 32'h0);
		// warnings only, alert on output zero
		wr(A_OUTCFG, 32'h12);
		warn_in <= 1'b1;
		cyc(2);
		@(negedge hclk);
		chk(go0_n, 0);
		chk(go3_n, 1);
		@(posedge hclk);
		warn_in <= 1'b0;
		wr(A_OUTCFG, RST_OUTCFG);
		raise(F_CLT);
		cyc(4);
		raise(F_SOC);
		cyc(4);
		rdm(A_STATE, (1 << 15) | (F_SOC << 11) | (1 << 10) | (F_CLT << 6), 32'hFFC0);
		@(posedge hclk);
		fault_cond <= NF'(1) << F_CLT;
		service_done <= 1'b1;
		@(posedge hclk);
		service_done <= 1'b0;
		cyc(3);
		rdm(A_STATE, (1 << 15) | (F_CLT << 11) | (F_CLT << 6), 32'hFFC0);
		fin(1'b1);
		wr(A_CMD, 32'h2);
		@(negedge hclk);
		chk(ten_second_wait_state, 1);
		cyc(RC - 6);
		@(negedge hclk);
		chk(ten_second_wait_state, 1);
		n = 0;
		while (standby_request !== 1'b1 && n < 20)
		begin
			@(negedge hclk);
			n++;
		end
		chk(standby_request, 1);
		chk(n, RC - 54);
		cyc(3);
		test_done;
	end
endmodule : fault_manager_turnoff_seq_bench
